// File: design/weekly_switch_pkg.sv
// Shared types and constants of the seven-day time switch block.
// Assumes a battery-backed clock that delivers weekday, hour and minute.
package weekly_switch_pkg;

   localparam int NUM_SWITCHES = 4;
   localparam int NUM_CHANNELS = 4;
   localparam int NUM_SLOTS    = NUM_SWITCHES * NUM_CHANNELS;

   localparam int CLK_HZ       = 50_000_000;

   // Minutes in one week; the power-up scan walks back this far
   localparam int WEEK_MINUTES = 7 * 24 * 60;
   localparam int SCAN_CNT_W   = 14;

   localparam logic [2:0] DAY_MON  = 3'h0;
   localparam logic [2:0] DAY_SUN  = 3'h6;
   localparam logic [4:0] HOUR_MAX = 5'h17;
   localparam logic [5:0] MIN_MAX  = 6'h3b;

   // Register byte offsets
   localparam logic [7:0] CHAN_BASE  = 8'h00;
   localparam logic [7:0] CTRL_ADDR  = 8'h40;
   localparam logic [7:0] STAT_ADDR  = 8'h44;
   localparam logic [7:0] TIME_ADDR  = 8'h48;

   // Control register fields
   localparam int CTRL_RUN_BIT  = 0;
   localparam int CTRL_EDIT_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Status register fields
   localparam int STAT_CONTACT_LSB = 0;
   localparam int STAT_SCAN_BIT    = 4;
   localparam int STAT_POWER_BIT   = 5;

   typedef struct packed {
      logic [2:0] day;
      logic [4:0] hour;
      logic [5:0] minute;
   } clock_time_type;

   // One channel setting set, one register word, bit 31 reads zero
   typedef struct packed {
      logic       access;
      logic       offSet;
      logic [5:0] offMin;
      logic [4:0] offHour;
      logic       onSet;
      logic [5:0] onMin;
      logic [4:0] onHour;
      logic [2:0] dayLast;
      logic [2:0] dayFirst;
   } channel_type;

   localparam channel_type CHAN_RESET = 31'h0000_0000;

   typedef enum logic [2:0] {
      ST_DOWN = 3'h1,
      ST_SCAN = 3'h2,
      ST_RUN  = 3'h4
   } mode_type;

endpackage : weekly_switch_pkg

// File: design/weekly_time_switch.sv
// Four seven-day time switches, four channels each, with register port.
// Assumes the clock inputs and supply flag are synchronous to ref_clk.
// Function
// - Every switch has four independent channels A to D, each with settings.
// - A channel holds a weekday range, an on time and an off time or unset.
// - An off time earlier than the on time switches off on the next day.
// - Overlapping channels drive the contact by whichever event comes first.
// - The contact is off without supply and stays off if an off time passed.
// - At power-up the state is recomputed from all settings and the time.
// - On at midnight with off at midnight gives a full 24-hour on period.
// - A switch is only a readable contact with no coil to drive it.
// - Each channel has an access flag that allows or hides its settings.
// - The access flag changes only while the program is being edited.
// - The clock time is shown beside the settings only in run mode.
// - There are four switches, giving thirty-two switching instants.
// - The clock keeps counting on battery while all contacts are held open.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps

module channel_event
   import weekly_switch_pkg::*;
(
   input  channel_type    cfg,
   input  clock_time_type probe,
   output logic           onHit,
   output logic           offHit
);

   logic [2:0] yesterday;
   logic       todayIn;
   logic       yesterdayIn;
   logic       offNextDay;
   logic       onMatch;
   logic       offMatch;

   function automatic logic dayInRange(input logic [2:0] d,
                                       input logic [2:0] first,
                                       input logic [2:0] last);
      logic inRange;
      inRange = 1'b0;
      if (first <= last) begin
         inRange = (d >= first) && (d <= last);
      end else begin
         // Range wraps over the weekend, e.g. Friday to Monday
         inRange = (d >= first) || (d <= last);
      end
      return inRange && (d <= DAY_SUN);
   endfunction : dayInRange

   assign yesterday   = (probe.day == DAY_MON) ? DAY_SUN
                                               : probe.day - 3'h1;
   assign todayIn     = dayInRange(probe.day, cfg.dayFirst,
                                   cfg.dayLast);
   assign yesterdayIn = dayInRange(yesterday, cfg.dayFirst, cfg.dayLast);

   // Equal times also count as next day, so 0:00 to 0:00 lasts 24 hours
   assign offNextDay  = cfg.onSet &&
                        ({cfg.offHour, cfg.offMin} <=
                         {cfg.onHour, cfg.onMin});

   assign onMatch  = (probe.hour == cfg.onHour) &&
                     (probe.minute == cfg.onMin);
   assign offMatch = (probe.hour == cfg.offHour) &&
                     (probe.minute == cfg.offMin);

   assign onHit  = cfg.onSet && onMatch && todayIn;
   assign offHit = cfg.offSet && offMatch &&
                   (offNextDay ? yesterdayIn : todayIn);

endmodule : channel_event

module weekly_time_switch
   import weekly_switch_pkg::*;
#(
   parameter int SCAN_MINUTES = WEEK_MINUTES
)(
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic [7:0]              regAddr,
   input  wire logic [31:0]             writeData,
   input  wire logic                    writeStrobe,
   input  wire logic                    readStrobe,
   output logic [31:0]                  readData,
   input  wire logic                    supplyOk,
   input  clock_time_type               rtcTime,
   output logic [NUM_SWITCHES-1:0]      contact
);

   generate
      if (SCAN_MINUTES < 1 || SCAN_MINUTES >= (1 << SCAN_CNT_W)) begin
         $error("SCAN_MINUTES out of range");
      end
      // Channel words are indexed by four address bits below CTRL_ADDR
      if (NUM_SLOTS != 16) begin
         $error("channel count does not fit the register map");
      end
   endgenerate

   channel_type                  chan_r [NUM_SLOTS];
   logic [1:0]                   ctrl_r;
   mode_type                     mode_r;
   mode_type                     mode_nxt;
   clock_time_type               scanTime_r;
   clock_time_type               scanTime_nxt;
   logic [SCAN_CNT_W-1:0]        scanCount_r;
   logic [NUM_SWITCHES-1:0]      found_r;
   logic [NUM_SWITCHES-1:0]      found_nxt;
   logic [NUM_SWITCHES-1:0]      scanState_r;
   logic [NUM_SWITCHES-1:0]      scanState_nxt;
   logic [NUM_SWITCHES-1:0]      contact_r;
   logic [NUM_SWITCHES-1:0]      contact_nxt;
   logic [31:0]                  readData_r;

   clock_time_type               probe;
   logic [NUM_SLOTS-1:0]         chanOn;
   logic [NUM_SLOTS-1:0]         chanOff;
   logic [NUM_SWITCHES-1:0]      onAny;
   logic [NUM_SWITCHES-1:0]      offAny;
   logic [NUM_SWITCHES-1:0]      liveNext;
   logic [NUM_SWITCHES-1:0]      scanNew;
   logic                         scanLast;
   logic                         runMode;
   logic                         editMode;

   logic                         isChan;
   logic                         isCtrl;
   logic                         isStat;
   logic                         isTime;
   logic [3:0]                   chanIdx;
   channel_type                  chanCur;
   channel_type                  chanIn;
   channel_type                  chanWrData;
   logic                         onValid;
   logic                         offValid;
   logic                         chanWrEn;
   logic                         ctrlWrEn;
   logic [31:0]                  chanRead;
   logic [31:0]                  timeRead;
   logic [31:0]                  statRead;
   logic [31:0]                  readNxt;

   assign runMode  = ctrl_r[CTRL_RUN_BIT];
   assign editMode = ctrl_r[CTRL_EDIT_BIT];

   // Scanning evaluates past minutes; otherwise the live clock is used
   assign probe = (mode_r == ST_SCAN) ? scanTime_r : rtcTime;

   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++) begin : gSlot
         channel_event uEvent (
            .cfg    (chan_r[g]),
            .probe  (probe),
            .onHit  (chanOn[g]),
            .offHit (chanOff[g])
         );
      end
      for (g = 0; g < NUM_SWITCHES; g++) begin : gSwitch
         assign onAny[g]  = |chanOn[g*NUM_CHANNELS +: NUM_CHANNELS];
         assign offAny[g] = |chanOff[g*NUM_CHANNELS +: NUM_CHANNELS];
      end
   endgenerate

   // The earliest event of any channel moves the contact; a switch-on in
   // the same minute as a switch-off wins so chained 24-hour days join
   assign liveNext = onAny | (contact_r & ~offAny);

   // Walking backwards, the first event met per switch is the latest one
   assign scanNew       = ~found_r & (onAny | offAny);
   assign scanState_nxt = (scanState_r & ~scanNew) |
                          (onAny & scanNew);
   assign found_nxt     = found_r | onAny | offAny;
   assign scanLast      = (scanCount_r == 14'h0001);

   always_comb begin
      scanTime_nxt = scanTime_r;
      if (scanTime_r.minute != 6'h00) begin
         scanTime_nxt.minute = scanTime_r.minute - 6'h01;
      end else begin
         scanTime_nxt.minute = MIN_MAX;
         if (scanTime_r.hour != 5'h00) begin
            scanTime_nxt.hour = scanTime_r.hour - 5'h01;
         end else begin
            scanTime_nxt.hour = HOUR_MAX;
            scanTime_nxt.day  = (scanTime_r.day == DAY_MON)
                                ? DAY_SUN : scanTime_r.day - 3'h1;
         end
      end
   end

   always_comb begin
      mode_nxt    = mode_r;
      contact_nxt = '0;
      case (mode_r)
         ST_DOWN: begin
            if (supplyOk) begin
               mode_nxt = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (!supplyOk) begin
               mode_nxt = ST_DOWN;
            end else if (scanLast) begin
               mode_nxt    = ST_RUN;
               contact_nxt = scanState_nxt;
            end
         end
         ST_RUN: begin
            if (!supplyOk) begin
               mode_nxt = ST_DOWN;
            end else begin
               contact_nxt = liveNext;
            end
         end
         default: begin
            mode_nxt = ST_DOWN;
         end
      endcase
   end

   // The clock runs on outside this block, so losing supply only opens
   // the contacts; nothing here needs to remember the old state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r    <= ST_DOWN;
         contact_r <= '0;
      end else begin
         mode_r    <= mode_nxt;
         contact_r <= contact_nxt;
      end
   end

   // A minute that ticks over during the short scan is caught afterwards,
   // because the live path re-evaluates the current minute every cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scanTime_r  <= '0;
         scanCount_r <= '0;
         found_r     <= '0;
         scanState_r <= '0;
      end else if (mode_r == ST_SCAN) begin
         scanTime_r  <= scanTime_nxt;
         scanCount_r <= scanCount_r - 14'h0001;
         found_r     <= found_nxt;
         scanState_r <= scanState_nxt;
      end else begin
         scanTime_r  <= rtcTime;
         scanCount_r <= SCAN_CNT_W'(SCAN_MINUTES);
         found_r     <= '0;
         scanState_r <= '0;
      end
   end

   // Register decode
   assign isChan  = (regAddr[7:6] == CHAN_BASE[7:6]) &&
                    (regAddr[1:0] == 2'h0);
   assign isCtrl  = (regAddr == CTRL_ADDR);
   assign isStat  = (regAddr == STAT_ADDR);
   assign isTime  = (regAddr == TIME_ADDR);
   assign chanIdx = regAddr[5:2];
   assign chanCur = chan_r[chanIdx];
   assign chanIn  = writeData[30:0];

   // Out-of-range times are stored as unset
   assign onValid  = (chanIn.onHour <= HOUR_MAX) &&
                     (chanIn.onMin <= MIN_MAX);
   assign offValid = (chanIn.offHour <= HOUR_MAX) &&
                     (chanIn.offMin <= MIN_MAX);

   always_comb begin
      chanWrData        = chanIn;
      chanWrData.onSet  = chanIn.onSet & onValid;
      chanWrData.offSet = chanIn.offSet & offValid;
      if (!editMode) begin
         chanWrData.access = chanCur.access;
      end
   end

   assign chanWrEn = writeStrobe && isChan &&
                     (editMode || chanCur.access);
   assign ctrlWrEn = writeStrobe && isCtrl;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            chan_r[i] <= CHAN_RESET;
         end
      end else if (chanWrEn) begin
         chan_r[chanIdx] <= chanWrData;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RESET;
      end else if (ctrlWrEn) begin
         ctrl_r <= writeData[1:0];
      end
   end

   // Read side: hidden channels read as zero outside editing
   assign chanRead = (editMode || chanCur.access)
                     ? {1'b0, chanCur} : 32'h0000_0000;
   assign timeRead = runMode
                     ? {18'h0_0000, rtcTime} : 32'h0000_0000;

   // Status is read-only; the contacts cannot be forced by software
   always_comb begin
      statRead = 32'h0000_0000;
      statRead[STAT_CONTACT_LSB +: NUM_SWITCHES] = contact_r;
      statRead[STAT_SCAN_BIT]  = (mode_r == ST_SCAN);
      statRead[STAT_POWER_BIT] = supplyOk;
   end

   always_comb begin
      if (isChan) begin
         readNxt = chanRead;
      end else if (isCtrl) begin
         readNxt = {30'h0000_0000, ctrl_r};
      end else if (isStat) begin
         readNxt = statRead;
      end else if (isTime) begin
         readNxt = timeRead;
      end else begin
         readNxt = 32'h0000_0000;
      end
   end

   // Clearing between reads keeps a stale word off the bus

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         readData_r <= 32'h0000_0000;
      end else if (readStrobe) begin
         readData_r <= readNxt;
      end else begin
         readData_r <= 32'h0000_0000;
      end
   end

   assign readData = readData_r;
   assign contact  = contact_r;

endmodule : weekly_time_switch

// File: tb/weekly_switch_properties.sv
// Port-level assertions for the weekly time switch.
// Assumes it is bound onto weekly_time_switch, one clock domain.
`timescale 1ns/1ps
module weekly_switch_checker
   import weekly_switch_pkg::*;
#(
   parameter int SCAN_MINUTES = WEEK_MINUTES
)(
   input wire logic                    ref_clk,
   input wire logic                    rst_n,
   input wire logic [7:0]              regAddr,
   input wire logic [31:0]             writeData,
   input wire logic                    writeStrobe,
   input wire logic                    readStrobe,
   input wire logic [31:0]             readData,
   input wire logic                    supplyOk,
   input clock_time_type               rtcTime,
   input wire logic [NUM_SWITCHES-1:0] contact
);
   // Shadow of the control bits, since the checker sees only the ports
   logic [1:0] ctrl_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) ctrl_r <= CTRL_RESET;
      else if (writeStrobe && regAddr == CTRL_ADDR) ctrl_r <= writeData[1:0];
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_no_supply; !supplyOk |=> contact == 4'h0; endproperty
   a_no_supply: assert property (p_no_supply)
      else $error("contact on without supply");
   property p_scan_hold;
      $rose(supplyOk) |=> (contact == 4'h0) [*8];
   endproperty
   a_scan_hold: assert property (p_scan_hold)
      else $error("contact on during recompute");
   property p_time_hidden; readStrobe && regAddr == TIME_ADDR
      && !ctrl_r[CTRL_RUN_BIT] |=> readData == 32'h0000_0000; endproperty
   a_time_hidden: assert property (p_time_hidden)
      else $error("time shown outside run");
   property p_time_shown; readStrobe && regAddr == TIME_ADDR
      && ctrl_r[CTRL_RUN_BIT] |=> readData[13:0] == $past(rtcTime); endproperty
   a_time_shown: assert property (p_time_shown)
      else $error("time not shown in run");
   property p_status; readStrobe && regAddr == STAT_ADDR |=> readData[3:0]
      == $past(contact) && readData[5] == $past(supplyOk); endproperty
   a_status: assert property (p_status)
      else $error("status does not match contacts");
   property p_unmapped; readStrobe && regAddr > TIME_ADDR
      |=> readData == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_ctrl; readStrobe && regAddr == CTRL_ADDR
      |=> readData == {30'h0000_0000, $past(ctrl_r)}; endproperty
   a_ctrl: assert property (p_ctrl)
      else $error("control readback wrong");
   property p_hidden; readStrobe && regAddr < CTRL_ADDR
      && !ctrl_r[CTRL_EDIT_BIT]
      |=> readData[30] || readData == 32'h0000_0000; endproperty
   a_hidden: assert property (p_hidden)
      else $error("locked channel visible");
   property p_read_idle;
      !readStrobe |=> readData == 32'h0000_0000; endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("read data outside its cycle");
endmodule : weekly_switch_checker

// File: tb/ladder_reader.sv
// Ladder program stand-in that reads the switch contacts each cycle.
// Assumes contact is a registered level from the switch block.
`timescale 1ns/1ps
module ladder_reader
   import weekly_switch_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic [NUM_SWITCHES-1:0] contact,
   output logic      [NUM_SWITCHES-1:0] seenContact
);
   // Read only: a switch has no coil the program could drive
   always @(posedge ref_clk) seenContact <= contact;
endmodule : ladder_reader

// File: tb/tb_top.sv
// Self-checking bench for the weekly time switch, shortened scan.
// Assumes the package, checker and ladder reader are compiled first.
`timescale 1ns/1ps
module tb_top;
   import weekly_switch_pkg::*;
   localparam int SCAN = 20;
   logic           ref_clk     = 1'b0;
   logic           rst_n       = 1'b0;
   logic [7:0]     regAddr     = 8'h00;
   logic [31:0]    writeData   = 32'h0000_0000;
   logic           writeStrobe = 1'b0;
   logic           readStrobe  = 1'b0;
   logic           supplyOk    = 1'b0;
   clock_time_type rtcTime     = '0;
   logic [31:0]    readData;
   logic [3:0]     contact;
   logic [3:0]     seenContact;
   int             n_errors    = 0;
   int             tests_run   = 0;
   int             seed;
   always #10 ref_clk = ~ref_clk;
   weekly_time_switch #(.SCAN_MINUTES(SCAN)) u_dut (.ref_clk(ref_clk),
      .rst_n(rst_n), .regAddr(regAddr), .writeData(writeData),
      .writeStrobe(writeStrobe), .readStrobe(readStrobe),
      .readData(readData), .supplyOk(supplyOk), .rtcTime(rtcTime),
      .contact(contact));
   ladder_reader u_reader (.ref_clk(ref_clk), .contact(contact),
      .seenContact(seenContact));
   function automatic logic [31:0] chan(input int f, l, onH, onM, onS,
                                        offH, offM, offS, acc);
      return {1'b0, 1'(acc), 1'(offS), 6'(offM), 5'(offH), 1'(onS),
              6'(onM), 5'(onH), 3'(l), 3'(f)};
   endfunction : chan
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic chkReg(input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected readData: expected %h seen %h", e, g);
      end
   endtask : chkReg
   task automatic chkCon(input logic [3:0] e);
      tests_run++;
      if (seenContact !== e) begin
         n_errors++;
         $display("unexpected contact: expected %h seen %h", e, seenContact);
      end
   endtask : chkCon
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge ref_clk);
      writeStrobe <= 1'b0;
   endtask : wr
   // Masked compare of one register read; data stands one cycle only
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffff_ffff);
      @(posedge ref_clk);
      regAddr <= a;
      readStrobe <= 1'b1;
      @(posedge ref_clk);
      readStrobe <= 1'b0;
      #1 chkReg(e & m, readData & m);
   endtask : rc
   task automatic at(input int d, h, m, input logic [3:0] e);
      @(posedge ref_clk);
      rtcTime <= {3'(d), 5'(h), 6'(m)};
      repeat (3) @(posedge ref_clk);
      #1 chkCon(e);
   endtask : at
   task automatic power(input logic on);
      @(posedge ref_clk);
      supplyOk <= on;
      rc(STAT_ADDR, on ? 32'h0000_0030 : 32'h0000_0000, 32'h0000_0030);
      repeat (SCAN + 2) @(posedge ref_clk);
      #1;
   endtask : power
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_errors++;
      test_done();
   end
   initial begin
      seed = $urandom(11887);
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rc(CTRL_ADDR, 32'h0000_0000);
      rc(CHAN_BASE, 32'h0000_0000);
      wr(CTRL_ADDR, 32'h0000_0002);
      wr(8'h00, chan(0, 0, 22, 0, 1, 6, 0, 1, 1));
      wr(8'h10, chan(0, 2, 16, 0, 1, 22, 0, 1, 1));
      wr(8'h14, chan(1, 2, 10, 0, 1, 22, 0, 1, 0));
      wr(8'h20, chan(1, 1, 0, 0, 1, 0, 0, 1, 1));
      wr(8'h30, chan(0, 0, 0, 0, 0, 10, 0, 1, 1));
      wr(8'h34, chan(0, 0, 9, 0, 1, 0, 0, 0, 1));
      wr(8'h3c, chan(6, 6, 24, 0, 1, 0, 60, 1, 1));
      rc(8'h3c, 32'h4000_0000, 32'h6002_0000);
      rc(8'h14, chan(1, 2, 10, 0, 1, 22, 0, 1, 0));
      rc(TIME_ADDR, 32'h0000_0000);
      wr(CTRL_ADDR, 32'h0000_0001);
      rc(8'h14, 32'h0000_0000);
      wr(8'h14, chan(1, 2, 11, 0, 1, 22, 0, 1, 1));
      wr(8'h00, chan(0, 0, 22, 0, 1, 6, 0, 1, 0));
      rc(8'h00, chan(0, 0, 22, 0, 1, 6, 0, 1, 1));
      rc(8'h4c, 32'h0000_0000);
      $display("test registers done");
      at(0, 9, 10, 4'h0);
      power(1'b1);
      chkCon(4'h8);
      rc(TIME_ADDR, 32'h0000_024a);
      at(0, 10, 0, 4'h0);
      for (int i = 0; i < 4; i++) at(0, 11, $urandom_range(59), 4'h0);
      at(0, 16, 0, 4'h2);
      at(0, 22, 0, 4'h1);
      at(1, 0, 0, 4'h5);
      rc(STAT_ADDR, 32'h0000_0025, 32'h0000_003f);
      at(1, 6, 0, 4'h4);
      at(1, 10, 0, 4'h6);
      at(1, 22, 0, 4'h4);
      at(1, 23, 59, 4'h4);
      at(2, 0, 0, 4'h0);
      $display("test schedule done");
      at(2, 10, 0, 4'h2);
      power(1'b0);
      chkCon(4'h0);
      at(2, 22, 10, 4'h0);
      power(1'b1);
      chkCon(4'h0);
      $display("test power done");
      test_done();
   end
endmodule : tb_top
bind weekly_time_switch weekly_switch_checker #(.SCAN_MINUTES(SCAN_MINUTES))
   u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
   .writeData(writeData), .writeStrobe(writeStrobe),
   .readStrobe(readStrobe), .readData(readData), .supplyOk(supplyOk),
   .rtcTime(rtcTime), .contact(contact));
